// ### drive_control_state_machine.sv
// drive control state machine: command word decode and state report
//
// Behaviour
// (RL1) command word acts only in state machine mode
// (RL2) command word bit positions per field
// (RL3) switched on 0x33, enabled 0x37, fault bit3
// (RL4) decode shutdown, switch on, enable, disable
// (RL5) disable voltage, quick stop, fault reset edge
// (RL6) switch on needs voltage enabled bit
// (RL7) enable operation waits for torque release
// (RL8) release withdrawn drops enabled to switched on
// (RL9) non-motion enable needs release and start input
// (RL10) non-motion enable also needs voltage enabled
// (RL11) start inputs can be tied on or off
// (RL12) motion: movement needs extra high byte start
// (RL13) motion: release needed, start inputs ignored
// (RL14) mode bits and halt only in motion
// (RL15) status bits 12,13 only in positioning
// (RL16) status bit 4 mirrors mains voltage
// (RL17) status bit 7 shows internal warning
// (RL18) bit 10 target reached within tolerance
// (RL19) bit 11 internal limit active
// (RL20) bit 15 delayed warning before trip
// (RL21) encode remaining states in bits 6..0
// (RL22) bit 9 remote with mode and release
// (RL23) previous fault reset bit kept; reset state
// (RL24) one transition per clock, report next cycle
module drive_control_state_machine #(
  parameter int W = drive_control_pkg::WORD_W
) (
  input  wire logic                               core_clk,
  input  wire logic                               rstn,
  input  wire logic [W-1:0]                       cyclic_word_one,
  input  wire logic                               cyclic_word_valid,
  input  wire logic [7:0]                         local_remote_sel,
  input  wire logic                               motion_config,
  input  wire logic                               torque_release_in_a,
  input  wire logic                               torque_release_in_b,
  input  wire logic                               start_clockwise_in,
  input  wire logic                               start_anticlockwise_in,
  input  wire drive_control_pkg::tie_mode_type    tie_mode_clockwise,
  input  wire drive_control_pkg::tie_mode_type    tie_mode_anticlockwise,
  input  wire logic                               mains_present,
  input  wire logic                               fault_trip,
  input  wire logic                               fault_reaction_done,
  input  wire logic                               quick_stop_done,
  input  wire drive_control_pkg::drive_flags_type drive_flags,
  input  wire logic [W-1:0]                       actual_value,
  input  wire logic [W-1:0]                       reference_value,
  input  wire logic [W-1:0]                       target_tolerance,
  input  wire logic                               power_fail_zero,
  output logic [W-1:0]                            drive_command_word,
  output logic [W-1:0]                            drive_state_report_word,
  output drive_control_pkg::motion_bits_type      motion_bits,
  output logic                                    operation_enabled,
  output logic                                    motion_command_interface_armed
);

  // ------------------------------
  // reset release
  // ------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ------------------------------
  // decoding helpers
  // ------------------------------
  function automatic logic cmd_match(input logic [3:0] low,
                                     input logic [3:0] pat,
                                     input logic [3:0] mask);
    cmd_match = ((low & mask) == (pat & mask));
  endfunction

  function automatic logic [6:0] state_report(input drive_control_pkg::drive_state_type st);
    case (st) // see (RL21)
      drive_control_pkg::ST_SWITCH_ON_DIS: state_report = drive_control_pkg::RPT_SWITCH_ON_DIS;
      drive_control_pkg::ST_READY:         state_report = drive_control_pkg::RPT_READY;
      drive_control_pkg::ST_SWITCHED_ON:   state_report = drive_control_pkg::RPT_SWITCHED_ON; // see (RL3)
      drive_control_pkg::ST_OP_ENABLED:    state_report = drive_control_pkg::RPT_OP_ENABLED; // see (RL3)
      drive_control_pkg::ST_QUICK_STOP:    state_report = drive_control_pkg::RPT_QUICK_STOP;
      drive_control_pkg::ST_FAULT_REACT:   state_report = drive_control_pkg::RPT_FAULT_REACT; // see (RL3)
      drive_control_pkg::ST_FAULT:         state_report = drive_control_pkg::RPT_FAULT; // see (RL3)
      default:                             state_report = drive_control_pkg::RPT_SWITCH_ON_DIS;
    endcase
  endfunction

  // ------------------------------
  // command word capture
  // ------------------------------
  logic [W-1:0] cmd_reg;
  logic         fresh_reg;
  logic         fault_reset_prev_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg   <= '0;
      fresh_reg <= 1'b0;
    end else begin
      fresh_reg <= cyclic_word_valid; // see (RL24)
      if (cyclic_word_valid) begin
        cmd_reg <= cyclic_word_one;
      end
    end
  end

  // previous bit kept every clock so that one edge resets once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reset_prev_reg <= 1'b0;
    end else begin
      fault_reset_prev_reg <= cmd_reg[drive_control_pkg::CMD_FAULT_RESET]; // see (RL23)
    end
  end

  assign drive_command_word = cmd_reg;

  // ------------------------------
  // start sources and target detection
  // ------------------------------
  logic [1:0]                       start_sel;
  drive_control_pkg::tie_mode_type  tie_modes [2];
  logic                             target_reached;

  assign tie_modes[0] = tie_mode_clockwise;
  assign tie_modes[1] = tie_mode_anticlockwise;

  start_source_select #(
    .N         (2)
  ) u_start_sel (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .raw_in    ({start_anticlockwise_in, start_clockwise_in}),
    .tie_mode  (tie_modes),
    .start_out (start_sel)
  );

  target_window_compare #(
    .W               (W)
  ) u_target (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .actual_value    (actual_value),
    .reference_value (reference_value),
    .tolerance       (target_tolerance),
    .power_fail_zero (power_fail_zero),
    .reached         (target_reached)
  );

  // ------------------------------
  // command decode
  // ------------------------------
  logic [3:0] low_bits;
  logic       sm_mode;
  logic       act;
  logic       do_shutdown;
  logic       do_switch_on;
  logic       do_enable;
  logic       do_disable_voltage;
  logic       do_quick_stop;
  logic       do_fault_reset;
  logic       hw_release;
  logic       enable_allowed;

  assign low_bits = cmd_reg[3:0];
  assign sm_mode  = (local_remote_sel == drive_control_pkg::LOCAL_REMOTE_STATE_MACHINE);
  assign act      = sm_mode & fresh_reg; // see (RL1) see (RL24)

  // bit 7 is a don't care for these patterns
  assign do_shutdown = act & cmd_match(low_bits, drive_control_pkg::CMD_SHUTDOWN_PAT,
                                       drive_control_pkg::CMD_SHUTDOWN_MASK); // see (RL4)
  assign do_switch_on = act & cmd_match(low_bits, drive_control_pkg::CMD_SWITCH_ON_PAT,
                                        drive_control_pkg::CMD_ENABLE_PAT); // see (RL4)
  assign do_enable = act & cmd_match(low_bits, drive_control_pkg::CMD_ENABLE_PAT,
                                     drive_control_pkg::CMD_ENABLE_PAT); // see (RL4)
  assign do_disable_voltage = act & ~cmd_reg[drive_control_pkg::CMD_EN_VOLTAGE]; // see (RL5) see (RL2)
  assign do_quick_stop = act & cmd_reg[drive_control_pkg::CMD_EN_VOLTAGE]
                       & ~cmd_reg[drive_control_pkg::CMD_QUICK_STOP_N]; // see (RL5)
  // edge is looked at every clock, a word repeat cannot re-trigger it
  assign do_fault_reset = sm_mode & cmd_reg[drive_control_pkg::CMD_FAULT_RESET]
                        & ~fault_reset_prev_reg; // see (RL5)

  assign hw_release = torque_release_in_a & torque_release_in_b;

  // motion needs only the release
  assign enable_allowed = motion_config ? hw_release // see (RL13)
                        : (hw_release & (|start_sel) & mains_present); // see (RL9) see (RL10)

  // ------------------------------
  // state register
  // ------------------------------
  drive_control_pkg::drive_state_type state_reg;
  drive_control_pkg::drive_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (fault_trip &&
        state_reg != drive_control_pkg::ST_FAULT_REACT &&
        state_reg != drive_control_pkg::ST_FAULT) begin
      state_next = drive_control_pkg::ST_FAULT_REACT;
    end else begin
      case (state_reg)
        drive_control_pkg::ST_SWITCH_ON_DIS: begin
          if (do_shutdown) begin
            state_next = drive_control_pkg::ST_READY;
          end
        end
        drive_control_pkg::ST_READY: begin
          if (do_disable_voltage || do_quick_stop) begin
            state_next = drive_control_pkg::ST_SWITCH_ON_DIS; // see (RL5)
          end else if (do_switch_on && mains_present) begin
            state_next = drive_control_pkg::ST_SWITCHED_ON; // see (RL6)
          end
        end
        drive_control_pkg::ST_SWITCHED_ON: begin
          if (do_disable_voltage || do_quick_stop) begin
            state_next = drive_control_pkg::ST_SWITCH_ON_DIS;
          end else if (do_shutdown) begin
            state_next = drive_control_pkg::ST_READY;
          end else if (do_enable && enable_allowed) begin
            state_next = drive_control_pkg::ST_OP_ENABLED; // see (RL7)
          end
        end
        drive_control_pkg::ST_OP_ENABLED: begin
          if (do_disable_voltage) begin
            state_next = drive_control_pkg::ST_SWITCH_ON_DIS;
          end else if (do_quick_stop) begin
            state_next = drive_control_pkg::ST_QUICK_STOP;
          end else if (do_shutdown) begin
            state_next = drive_control_pkg::ST_READY;
          end else if (do_switch_on || !hw_release) begin
            state_next = drive_control_pkg::ST_SWITCHED_ON; // see (RL8)
          end
        end
        drive_control_pkg::ST_QUICK_STOP: begin
          if (do_disable_voltage || quick_stop_done) begin
            state_next = drive_control_pkg::ST_SWITCH_ON_DIS;
          end
        end
        drive_control_pkg::ST_FAULT_REACT: begin
          if (fault_reaction_done) begin
            state_next = drive_control_pkg::ST_FAULT;
          end
        end
        drive_control_pkg::ST_FAULT: begin
          // a pending trip holds the drive in fault
          if (do_fault_reset && !fault_trip) begin
            state_next = drive_control_pkg::ST_SWITCH_ON_DIS; // see (RL5)
          end
        end
        default: state_next = drive_control_pkg::ST_SWITCH_ON_DIS;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= drive_control_pkg::ST_SWITCH_ON_DIS; // see (RL23)
    end else begin
      state_reg <= state_next; // see (RL24)
    end
  end

  // ------------------------------
  // state report word
  // ------------------------------
  logic [W-1:0] report_next;

  always_comb begin
    report_next                                 = '0;
    report_next[drive_control_pkg::STS_STATE_HI:0] = state_report(state_reg);
    report_next[drive_control_pkg::STS_VOLTAGE]     = mains_present; // see (RL16)
    report_next[drive_control_pkg::STS_WARNING]     = drive_flags.warning; // see (RL17)
    report_next[drive_control_pkg::STS_REMOTE]      = sm_mode & hw_release; // see (RL22)
    report_next[drive_control_pkg::STS_TARGET]      = target_reached; // see (RL18)
    report_next[drive_control_pkg::STS_LIMIT]       = drive_flags.limit_active; // see (RL19)
    report_next[drive_control_pkg::STS_MODE_LO]     = motion_config & drive_flags.mode_bit_lo; // see (RL15)
    report_next[drive_control_pkg::STS_MODE_HI]     = motion_config & drive_flags.mode_bit_hi; // see (RL15)
    report_next[drive_control_pkg::STS_WARNING_TWO] = drive_flags.warning_two; // see (RL20)
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_state_report_word <= {{(W-7){1'b0}}, drive_control_pkg::RPT_SWITCH_ON_DIS};
    end else begin
      drive_state_report_word <= report_next; // see (RL24)
    end
  end

  // ------------------------------
  // motion side outputs
  // ------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      motion_bits <= '0;
    end else if (motion_config && sm_mode) begin
      motion_bits.halt      <= cmd_reg[drive_control_pkg::CMD_HALT]; // see (RL14)
      motion_bits.mode_nine <= cmd_reg[drive_control_pkg::CMD_MODE_NINE];
      motion_bits.mode_bits <= cmd_reg[drive_control_pkg::CMD_MODE_HI:drive_control_pkg::CMD_MODE_LO];
      motion_bits.mfr_bits  <= cmd_reg[drive_control_pkg::CMD_MFR_HI:drive_control_pkg::CMD_MFR_LO];
    end else begin
      motion_bits <= '0; // see (RL14)
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      operation_enabled              <= 1'b0;
      motion_command_interface_armed <= 1'b0;
    end else begin
      operation_enabled <= (state_reg == drive_control_pkg::ST_OP_ENABLED);
      // high byte start is decoded downstream
      motion_command_interface_armed <= motion_config &
                                        (state_reg == drive_control_pkg::ST_OP_ENABLED); // see (RL12)
    end
  end

endmodule // drive_control_state_machine

// ### drive_control_pkg.sv
// shared constants, types and codes of the drive control state machine
package drive_control_pkg;

  // ------------------------------
  // word layout
  // ------------------------------
  localparam int WORD_W = 16;

  localparam int CMD_SWITCH_ON    = 0;
  localparam int CMD_EN_VOLTAGE   = 1;
  localparam int CMD_QUICK_STOP_N = 2;
  localparam int CMD_EN_OPERATION = 3;
  localparam int CMD_MODE_LO      = 4;
  localparam int CMD_MODE_HI      = 6;
  localparam int CMD_FAULT_RESET  = 7;
  localparam int CMD_HALT         = 8;
  localparam int CMD_MODE_NINE    = 9;
  localparam int CMD_MFR_LO       = 12;
  localparam int CMD_MFR_HI       = 15;

  localparam int STS_STATE_HI     = 6;
  localparam int STS_FAULT        = 3;
  localparam int STS_VOLTAGE      = 4;
  localparam int STS_WARNING      = 7;
  localparam int STS_REMOTE       = 9;
  localparam int STS_TARGET       = 10;
  localparam int STS_LIMIT        = 11;
  localparam int STS_MODE_LO      = 12;
  localparam int STS_MODE_HI      = 13;
  localparam int STS_WARNING_TWO  = 15;

  // ------------------------------
  // command patterns on bits 3..0
  // ------------------------------
  localparam logic [3:0] CMD_LOW_MASK      = 4'h7;
  localparam logic [3:0] CMD_SHUTDOWN_PAT  = 4'h6;
  localparam logic [3:0] CMD_SHUTDOWN_MASK = 4'h7;
  localparam logic [3:0] CMD_SWITCH_ON_PAT = 4'h7;
  localparam logic [3:0] CMD_ENABLE_PAT    = 4'hf;

  // ------------------------------
  // state report patterns on bits 6..0
  // ------------------------------
  localparam logic [6:0] RPT_SWITCH_ON_DIS = 7'h40;
  localparam logic [6:0] RPT_READY         = 7'h21;
  localparam logic [6:0] RPT_SWITCHED_ON   = 7'h33;
  localparam logic [6:0] RPT_OP_ENABLED    = 7'h37;
  localparam logic [6:0] RPT_QUICK_STOP    = 7'h07;
  localparam logic [6:0] RPT_FAULT_REACT   = 7'h0f;
  localparam logic [6:0] RPT_FAULT         = 7'h08;

  // ------------------------------
  // settings
  // ------------------------------
  localparam logic [7:0] LOCAL_REMOTE_STATE_MACHINE = 8'h01;

  typedef enum logic [1:0] {
    TIE_WIRED = 2'h0,
    TIE_ON    = 2'h1,
    TIE_OFF   = 2'h2
  } tie_mode_type;

  typedef enum logic [2:0] {
    ST_SWITCH_ON_DIS = 3'h0,
    ST_READY         = 3'h1,
    ST_SWITCHED_ON   = 3'h3,
    ST_OP_ENABLED    = 3'h2,
    ST_QUICK_STOP    = 3'h6,
    ST_FAULT_REACT   = 3'h7,
    ST_FAULT         = 3'h5
  } drive_state_type;

  typedef struct packed {
    logic warning;
    logic limit_active;
    logic warning_two;
    logic mode_bit_lo;
    logic mode_bit_hi;
  } drive_flags_type;

  typedef struct packed {
    logic       halt;
    logic       mode_nine;
    logic [2:0] mode_bits;
    logic [3:0] mfr_bits;
  } motion_bits_type;

endpackage

// ### start_source_select.sv
// start input selection: wired input or tied on or off per input
module start_source_select #(
  parameter int N = 2
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_n,
  input  wire logic [N-1:0]                         raw_in,
  input  wire drive_control_pkg::tie_mode_type      tie_mode [N],
  output logic      [N-1:0]                         start_out
);

  // ------------------------------
  // per input selection
  // ------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_src
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          start_out[g] <= 1'b0;
        end else begin
          case (tie_mode[g]) // see (RL11)
            drive_control_pkg::TIE_WIRED: start_out[g] <= raw_in[g];
            drive_control_pkg::TIE_ON:    start_out[g] <= 1'b1;
            drive_control_pkg::TIE_OFF:   start_out[g] <= 1'b0;
            default:                      start_out[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

endmodule // start_source_select

// ### target_window_compare.sv
// target reached detection with a tolerance window
module target_window_compare #(
  parameter int W = 16
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic [W-1:0]  actual_value,
  input  wire logic [W-1:0]  reference_value,
  input  wire logic [W-1:0]  tolerance,
  input  wire logic          power_fail_zero,
  output logic               reached
);

  // ------------------------------
  // distance
  // ------------------------------
  logic [W-1:0] distance;

  // unsigned magnitude; signed speeds must be offset by the user
  assign distance = (actual_value >= reference_value) ?
                    W'(actual_value - reference_value) :
                    W'(reference_value - actual_value);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reached <= 1'b0;
    end else begin
      reached <= (distance <= tolerance) | power_fail_zero; // see (RL18)
    end
  end

endmodule // target_window_compare

// ### drive_control_state_machine_chk.sv
// checker: port-level properties of the drive control state machine
module drive_control_state_machine_chk #(
  parameter int W = drive_control_pkg::WORD_W
) (
  input wire logic                               core_clk,
  input wire logic                               rstn,
  input wire logic [W-1:0]                       cyclic_word_one,
  input wire logic                               cyclic_word_valid,
  input wire logic [7:0]                         local_remote_sel,
  input wire logic                               motion_config,
  input wire logic                               torque_release_in_a,
  input wire logic                               torque_release_in_b,
  input wire logic                               mains_present,
  input wire logic                               fault_trip,
  input wire logic [W-1:0]                       drive_command_word,
  input wire logic [W-1:0]                       drive_state_report_word,
  input wire drive_control_pkg::motion_bits_type motion_bits,
  input wire logic                               operation_enabled
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------
  // properties
  // ------------------------------
  // internal reset lifts two edges late
  logic [2:0] up_cnt_reg;
  logic       run;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) up_cnt_reg <= 3'h0;
    else if (up_cnt_reg != 3'h4) up_cnt_reg <= up_cnt_reg + 3'h1;
  end
  assign run = (up_cnt_reg == 3'h4);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn || !run);
  a_word_capture: assert property (cyclic_word_valid |=> drive_command_word == $past(cyclic_word_one))
    else $error("command word not captured");
  a_enabled_pattern: assert property (operation_enabled |-> drive_state_report_word[6:5] == 2'h1 && drive_state_report_word[3:0] == 4'h7)
    else $error("enabled state not reported");
  a_release_gate: assert property ($rose(operation_enabled) |-> $past(torque_release_in_a && torque_release_in_b, 2))
    else $error("enabled without release");
  a_release_drop: assert property (operation_enabled && !(torque_release_in_a && torque_release_in_b) |=> ##1 !operation_enabled)
    else $error("release withdrawn but still enabled");
  a_local_ignore: assert property ($past(local_remote_sel) != 8'h01 && !operation_enabled |=> !operation_enabled)
    else $error("enabled outside state machine mode");
  a_motion_quiet: assert property (!motion_config [*2] |-> motion_bits == 9'h000)
    else $error("motion bits outside motion config");
  a_fault_flag: assert property (fault_trip [*3] |-> drive_state_report_word[3])
    else $error("fault bit missing");
  a_mains_bit: assert property (mains_present [*3] |-> drive_state_report_word[4])
    else $error("voltage bit missing");
  a_remote_bit: assert property (!(local_remote_sel == 8'h01 && torque_release_in_a && torque_release_in_b) [*3] |-> !drive_state_report_word[9])
    else $error("remote bit without release");
endmodule // drive_control_state_machine_chk

bind drive_control_state_machine drive_control_state_machine_chk #(.W(W)) chk_u (.*);

// ### plc_master_model.sv
// fieldbus master model: offers one command word per cyclic update
module plc_master_model (
  input  wire logic        core_clk,
  output logic      [15:0] cyclic_word_one,
  output logic             cyclic_word_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cyclic_word_one = 16'h0000;
    cyclic_word_valid = 1'b0;
  end
  // one-cycle word, then its inverse to catch a late read
  task automatic send(input logic [15:0] w);
    @(posedge core_clk);
    #1;
    cyclic_word_one = w;
    cyclic_word_valid = 1'b1;
    @(posedge core_clk);
    #1;
    cyclic_word_valid = 1'b0;
    cyclic_word_one = ~w;
  endtask
endmodule // plc_master_model

// ### drive_control_state_machine_tb_top.sv
// self-checking bench of the drive control state machine
module drive_control_state_machine_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                               core_clk, rstn, cyclic_word_valid, motion_config, mains_present;
  logic                               torque_release_in_a, torque_release_in_b, power_fail_zero;
  logic                               start_clockwise_in, start_anticlockwise_in, fault_trip;
  logic                               fault_reaction_done, quick_stop_done, operation_enabled;
  logic                               motion_command_interface_armed;
  logic [7:0]                         local_remote_sel;
  logic [15:0]                        cyclic_word_one, actual_value, reference_value, target_tolerance;
  logic [15:0]                        drive_command_word, drive_state_report_word;
  drive_control_pkg::tie_mode_type    tie_mode_clockwise, tie_mode_anticlockwise;
  drive_control_pkg::drive_flags_type drive_flags;
  drive_control_pkg::motion_bits_type motion_bits;
  int                                 err_total, tests_run;

  drive_control_state_machine dut_u (.*);
  plc_master_model plc_u (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // evaluation, report, registered start inputs
  task automatic st(input logic [6:0] exp);
    repeat (3) @(posedge core_clk);
    #1;
    chk({9'h000, drive_state_report_word[6:0]}, {9'h000, exp});
  endtask
  task automatic go(input logic [15:0] w, input logic [6:0] exp);
    plc_u.send(w);
    st(exp);
  endtask
  task automatic close_out();
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_refuse();
    go(16'h0006, 7'h40);
    local_remote_sel = 8'h01;
    go(16'h0006, 7'h21);
    go(16'h0007, 7'h21);
    mains_present = 1'b1;
    go(16'h0007, 7'h33);
    go(16'h000f, 7'h33);
    torque_release_in_a = 1'b1;
    torque_release_in_b = 1'b1;
    go(16'h000f, 7'h33);
    tie_mode_anticlockwise = drive_control_pkg::TIE_ON;
    mains_present = 1'b0;
    go(16'h000f, 7'h23);
    mains_present = 1'b1;
    go(16'h000f, 7'h37);
    torque_release_in_b = 1'b0;
    st(7'h33);
  endtask
  task automatic t_walk();
    torque_release_in_b = 1'b1;
    tie_mode_anticlockwise = drive_control_pkg::TIE_OFF;
    start_clockwise_in = 1'b1;
    go(16'h017f, 7'h37);
    chk({7'h00, motion_bits}, 16'h0000);
    chk({6'h00, drive_state_report_word[9], 9'h000}, 16'h0200);
    go(16'h0007, 7'h33);
    go(16'h000e, 7'h31);
    go(16'h0007, 7'h33);
    go(16'h000f, 7'h37);
    go(16'h000b, 7'h17);
    quick_stop_done = 1'b1;
    st(7'h50);
    quick_stop_done = 1'b0;
    go(16'h0006, 7'h31);
    go(16'h0004, 7'h50);
  endtask
  task automatic t_fault();
    go(16'h0006, 7'h31);
    fault_trip = 1'b1;
    st(7'h1f);
    fault_reaction_done = 1'b1;
    st(7'h18);
    fault_trip = 1'b0;
    fault_reaction_done = 1'b0;
    go(16'h0006, 7'h18);
    go(16'h0080, 7'h50);
  endtask
  task automatic t_motion();
    motion_config = 1'b1;
    start_clockwise_in = 1'b0;
    tie_mode_clockwise = drive_control_pkg::TIE_OFF;
    go(16'h0006, 7'h31);
    go(16'h0007, 7'h33);
    go(16'h010f, 7'h37);
    chk({7'h00, motion_bits}, 16'h0100);
    chk({15'h0000, motion_command_interface_armed}, 16'h0001);
    go(16'h0000, 7'h50);
  endtask
  task automatic t_flags();
    drive_flags = 5'b11111;
    target_tolerance = 16'h0003;
    st(7'h50);
    chk(drive_state_report_word & 16'hbc80, 16'hbc80);
    motion_config = 1'b0;
    drive_flags = 5'b00011;
    target_tolerance = 16'h0002;
    st(7'h50);
    chk(drive_state_report_word & 16'hbc80, 16'h0000);
    power_fail_zero = 1'b1;
    st(7'h50);
    chk(drive_state_report_word & 16'h0400, 16'h0400);
  endtask
  // ------------------------------
  // run
  // ------------------------------
  initial begin
    err_total = 0;
    tests_run = 0;
    rstn = 1'b0;
    local_remote_sel = 8'h00;
    {motion_config, mains_present, fault_trip, fault_reaction_done, quick_stop_done, power_fail_zero} = 6'h00;
    {torque_release_in_a, torque_release_in_b, start_clockwise_in, start_anticlockwise_in} = 4'h0;
    tie_mode_clockwise = drive_control_pkg::TIE_WIRED;
    tie_mode_anticlockwise = drive_control_pkg::TIE_WIRED;
    drive_flags = 5'b00000;
    actual_value = 16'h0064;
    reference_value = 16'h0067;
    target_tolerance = 16'h0000;
    repeat (2) @(posedge core_clk);
    #1;
    chk(drive_state_report_word, 16'h0040);
    chk(drive_command_word, 16'h0000);
    rstn = 1'b1;
    st(7'h40);
    t_refuse();
    t_walk();
    t_fault();
    t_motion();
    t_flags();
    close_out();
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    err_total++;
    close_out();
  end
endmodule // drive_control_state_machine_tb_top
